// file: design/mbst_pkg.sv
package mbst_pkg;
  // ==========================================
  // scan register lengths
  localparam int unsigned IR_LEN = 3;
  localparam int unsigned ID_LEN = 32;
  localparam int unsigned BSR_LEN = 109;
  // ==========================================
  // instruction codes
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_HIZ_SAMPLE = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
  // ==========================================
  // identification fields
  localparam int unsigned ID_VER_LSB = 29;
  localparam int unsigned ID_PART_LSB = 12;
  localparam int unsigned ID_MFR_LSB = 1;
  // arbitrary value
  localparam logic [2:0] ID_VERSION = 3'h0;
  // arbitrary value
  localparam logic [16:0] ID_PART = 17'h00123;
  // arbitrary value
  localparam logic [10:0] ID_MFR = 11'h055;
  localparam logic ID_PRESENT = 1'b1;
  localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MFR, ID_PRESENT};
  // ==========================================
  // boundary cell that enables read outputs under extest
  localparam int unsigned BSR_OE_CELL = 108;
  // ==========================================
  // tap controller states
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
  } mbst_state_t;
endpackage

// file: design/mbst_edge_if.sv
`timescale 1ns/1ns
// ==========================================
// synchronised link signals and edge strobes
interface mbst_edge_if;
  logic rise;
  logic fall;
  logic tms;
  logic tdi;
  modport src (output rise, output fall, output tms, output tdi);
  modport dst (input rise, input fall, input tms, input tdi);
endinterface

// file: design/mbst_sync.sv
`timescale 1ns/1ns
// ==========================================
// two-flop synchronisers and tck edge detection
module mbst_sync (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  mbst_edge_if.src e
);
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic tck_d_r;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // tck idles low, tms and tdi high
      s1_r <= 3'h3;
      s2_r <= 3'h3;
      tck_d_r <= 1'b0;
    end else begin
      s1_r <= {i_tck, i_tms, i_tdi};
      s2_r <= s1_r;
      tck_d_r <= s2_r[2];
    end
  end
  assign e.rise = s2_r[2] & ~tck_d_r;
  assign e.fall = ~s2_r[2] & tck_d_r;
  assign e.tms = s2_r[1];
  assign e.tdi = s2_r[0];
endmodule

// file: design/mbst_tap.sv
`timescale 1ns/1ns
// ==========================================
// Overview of operation
// - sample tms each tck rise for state
// - tdo changes only after tck fall
// - extest captures pin ring into bsr
// - idcode loads id, routes, memory unaffected
// - hiz sample captures, routes bsr, tristates outputs
// - sample/preload captures, routes bsr, no effect
// - bypass routes one-bit register, no effect
// - id holds version and part fields
// - id bits 11:1 hold manufacturer code
// - id bit zero always one
// - reset state loads idcode instruction
// - capture-ir loads low bits with 01
// - cell 108 gates outputs under extest
// - shift from tdi, msb nearest tdi
module mbst_tap (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic [108:0] i_pins,
  output logic o_tdo,
  output logic o_tdo_oe_n,
  output logic o_q_oe_n,
  output logic o_extest,
  output logic [108:0] o_bsr_update
);
  // ==========================================
  // link sampling
  mbst_edge_if e ();
  mbst_sync u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_tck(i_tck),
    .i_tms(i_tms),
    .i_tdi(i_tdi),
    .e(e)
  );

  mbst_pkg::mbst_state_t st_r;
  mbst_pkg::mbst_state_t st_nxt;
  logic [mbst_pkg::IR_LEN-1:0] ir_sh_r;
  logic [mbst_pkg::IR_LEN-1:0] ir_r;
  logic byp_r;
  logic [mbst_pkg::ID_LEN-1:0] id_r;
  logic [mbst_pkg::BSR_LEN-1:0] bsr_r;
  logic [mbst_pkg::BSR_LEN-1:0] upd_r;
  logic tdo_r;
  logic tdo_oe_n_r;
  logic q_oe_n_r;
  logic extest_r;
  logic [mbst_pkg::BSR_LEN-1:0] pins_s1_r;
  logic [mbst_pkg::BSR_LEN-1:0] pins_s2_r;

  // ==========================================
  // pin ring synchroniser
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pins_s1_r <= '0;
      pins_s2_r <= '0;
    end else begin
      pins_s1_r <= i_pins;
      pins_s2_r <= pins_s1_r;
    end
  end

  // ==========================================
  // next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      mbst_pkg::ST_RESET: st_nxt = e.tms ? mbst_pkg::ST_RESET : mbst_pkg::ST_IDLE;
      mbst_pkg::ST_IDLE: st_nxt = e.tms ? mbst_pkg::ST_SEL_DR : mbst_pkg::ST_IDLE;
      mbst_pkg::ST_SEL_DR: st_nxt = e.tms ? mbst_pkg::ST_SEL_IR : mbst_pkg::ST_CAP_DR;
      mbst_pkg::ST_CAP_DR: st_nxt = e.tms ? mbst_pkg::ST_EX1_DR : mbst_pkg::ST_SH_DR;
      mbst_pkg::ST_SH_DR: st_nxt = e.tms ? mbst_pkg::ST_EX1_DR : mbst_pkg::ST_SH_DR;
      mbst_pkg::ST_EX1_DR: st_nxt = e.tms ? mbst_pkg::ST_UPD_DR : mbst_pkg::ST_PA_DR;
      mbst_pkg::ST_PA_DR: st_nxt = e.tms ? mbst_pkg::ST_EX2_DR : mbst_pkg::ST_PA_DR;
      mbst_pkg::ST_EX2_DR: st_nxt = e.tms ? mbst_pkg::ST_UPD_DR : mbst_pkg::ST_SH_DR;
      mbst_pkg::ST_UPD_DR: st_nxt = e.tms ? mbst_pkg::ST_SEL_DR : mbst_pkg::ST_IDLE;
      mbst_pkg::ST_SEL_IR: st_nxt = e.tms ? mbst_pkg::ST_RESET : mbst_pkg::ST_CAP_IR;
      mbst_pkg::ST_CAP_IR: st_nxt = e.tms ? mbst_pkg::ST_EX1_IR : mbst_pkg::ST_SH_IR;
      mbst_pkg::ST_SH_IR: st_nxt = e.tms ? mbst_pkg::ST_EX1_IR : mbst_pkg::ST_SH_IR;
      mbst_pkg::ST_EX1_IR: st_nxt = e.tms ? mbst_pkg::ST_UPD_IR : mbst_pkg::ST_PA_IR;
      mbst_pkg::ST_PA_IR: st_nxt = e.tms ? mbst_pkg::ST_EX2_IR : mbst_pkg::ST_PA_IR;
      mbst_pkg::ST_EX2_IR: st_nxt = e.tms ? mbst_pkg::ST_UPD_IR : mbst_pkg::ST_SH_IR;
      mbst_pkg::ST_UPD_IR: st_nxt = e.tms ? mbst_pkg::ST_SEL_DR : mbst_pkg::ST_IDLE;
    endcase
  end

  // ==========================================
  // decode
  wire is_ext = (ir_r == mbst_pkg::INS_EXTEST);
  wire is_id = (ir_r == mbst_pkg::INS_IDCODE);
  wire is_hiz = (ir_r == mbst_pkg::INS_HIZ_SAMPLE);
  wire is_smp = (ir_r == mbst_pkg::INS_SAMPLE);
  wire is_byp = (ir_r == mbst_pkg::INS_BYPASS);
  wire sel_bsr = is_ext | is_hiz | is_smp;
  wire in_reset = (st_r == mbst_pkg::ST_RESET);
  wire cap_dr = (st_r == mbst_pkg::ST_CAP_DR);
  wire sh_dr = (st_r == mbst_pkg::ST_SH_DR);
  wire upd_dr = (st_r == mbst_pkg::ST_UPD_DR);
  wire cap_ir = (st_r == mbst_pkg::ST_CAP_IR);
  wire sh_ir = (st_r == mbst_pkg::ST_SH_IR);
  wire upd_ir = (st_r == mbst_pkg::ST_UPD_IR);
  wire dr_bit = sel_bsr ? bsr_r[0] : (is_id ? id_r[0] : byp_r);
  wire tdo_nxt = sh_ir ? ir_sh_r[0] : dr_bit;
  wire shifting = sh_ir | sh_dr;
  // outputs enabled unless hiz sample, or extest with cell 108 low
  wire q_off = is_hiz | (is_ext & ~upd_r[mbst_pkg::BSR_OE_CELL]);

  // ==========================================
  // tap state
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= mbst_pkg::ST_RESET;
    end else if (e.rise) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // instruction register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ir_sh_r <= mbst_pkg::INS_IDCODE;
      ir_r <= mbst_pkg::INS_IDCODE;
    end else if (e.rise) begin
      if (in_reset) begin
        ir_r <= mbst_pkg::INS_IDCODE;
      end else if (upd_ir) begin
        ir_r <= ir_sh_r;
      end
      if (cap_ir) begin
        ir_sh_r <= {1'b0, mbst_pkg::IR_CAPTURE_PAT};
      end else if (sh_ir) begin
        ir_sh_r <= {e.tdi, ir_sh_r[2:1]};
      end
    end
  end

  // ==========================================
  // bypass register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      byp_r <= 1'b0;
    end else if (e.rise) begin
      if (cap_dr && is_byp) begin
        byp_r <= 1'b0;
      end else if (sh_dr && is_byp) begin
        byp_r <= e.tdi;
      end
    end
  end

  // ==========================================
  // identification register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      id_r <= mbst_pkg::ID_WORD;
    end else if (e.rise) begin
      if (cap_dr && is_id) begin
        id_r <= mbst_pkg::ID_WORD;
      end else if (sh_dr && is_id) begin
        id_r <= {e.tdi, id_r[31:1]};
      end
    end
  end

  // ==========================================
  // boundary scan register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bsr_r <= '0;
    end else if (e.rise) begin
      if (cap_dr && sel_bsr) begin
        bsr_r <= pins_s2_r;
      end else if (sh_dr && sel_bsr) begin
        bsr_r <= {e.tdi, bsr_r[108:1]};
      end
    end
  end

  // ==========================================
  // update latches
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      upd_r <= '0;
      upd_r[mbst_pkg::BSR_OE_CELL] <= 1'b1;
    end else if (e.rise && in_reset) begin
      upd_r[mbst_pkg::BSR_OE_CELL] <= 1'b1;
    end else if (e.rise && upd_dr && sel_bsr) begin
      upd_r <= bsr_r;
    end
  end

  // ==========================================
  // outputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tdo_r <= 1'b0;
      tdo_oe_n_r <= 1'b1;
      q_oe_n_r <= 1'b0;
      extest_r <= 1'b0;
    end else begin
      if (e.fall) begin
        tdo_r <= tdo_nxt;
        tdo_oe_n_r <= ~shifting;
      end
      q_oe_n_r <= q_off;
      extest_r <= is_ext;
    end
  end

  assign o_tdo = tdo_r;
  assign o_tdo_oe_n = tdo_oe_n_r;
  assign o_q_oe_n = q_oe_n_r;
  assign o_extest = extest_r;
  assign o_bsr_update = upd_r;
endmodule

// file: dv/mbst_tap_properties.sv
`timescale 1ns/1ns
// ==========================================
// tap port checks
module mbst_tap_properties (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic [108:0] i_pins,
  input wire logic o_tdo,
  input wire logic o_tdo_oe_n,
  input wire logic o_q_oe_n,
  input wire logic o_extest,
  input wire logic [108:0] o_bsr_update
);
  logic [5:0] tck_r;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tck_r <= 6'h00;
    end else begin
      tck_r <= {tck_r[4:0], i_tck};
    end
  end
  wire fell_w = tck_r[5] & ~tck_r[1];
  wire rose_w = tck_r[1] & ~tck_r[5];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_tdo_after_fall: assert property ($changed(o_tdo) |-> fell_w)
    else $error("tdo moved without a tck fall");
  chk_oe_after_fall: assert property ($changed(o_tdo_oe_n) |-> fell_w)
    else $error("tdo enable moved without a tck fall");
  chk_tdo_sync_lag: assert property ($fell(i_tck) |=> $stable({o_tdo, o_tdo_oe_n})[*2])
    else $error("tdo moved too soon after tck fall");
  chk_bsr_on_rise: assert property ($changed(o_bsr_update) |-> rose_w)
    else $error("update latches moved without a tck rise");
  chk_extest_on_rise: assert property ($changed(o_extest) |-> rose_w)
    else $error("extest moved without a tck rise");
  chk_qoe_on_rise: assert property ($changed(o_q_oe_n) |-> rose_w)
    else $error("read enable moved without a tck rise");
  chk_reset_values: assert property ($rose(i_resetn) |-> o_tdo_oe_n && !o_extest
    && !o_q_oe_n && o_bsr_update == {1'h1, 108'h0})
    else $error("wrong values after reset");
  chk_extest_gate: assert property (o_extest && $stable(o_extest)
    && $stable(o_bsr_update[108]) |-> o_q_oe_n == !o_bsr_update[108])
    else $error("cell 108 does not gate read outputs");
endmodule
bind mbst_tap mbst_tap_properties mbst_tap_properties_i (.i_clk, .i_resetn, .i_tck, .i_tms,
  .i_tdi, .i_pins, .o_tdo, .o_tdo_oe_n, .o_q_oe_n, .o_extest, .o_bsr_update);

// file: dv/mbst_ctrl_model.sv
`timescale 1ns/1ns
// ==========================================
// test controller; tck idles low between scans
module mbst_ctrl_model (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  initial begin
    o_tck = 1'h0;
    o_tms = 1'h1;
    o_tdi = 1'h0;
  end
  task automatic step(input logic m, input logic d, output logic s);
    o_tms = m;
    o_tdi = d;
    #32 o_tck = 1'h1;
    s = i_tdo;
    #32 o_tck = 1'h0;
  endtask
  task automatic walk(input logic [7:0] ms, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      step(ms[i], 1'h0, q);
    end
  endtask
  task automatic shift(input logic [108:0] din, input int n, output logic [108:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    walk(8'h01, 2);
  endtask
  task automatic scan_dr(input logic [108:0] din, input int n, output logic [108:0] dout);
    walk(8'h01, 3);
    shift(din, n, dout);
  endtask
  task automatic scan_ir(input logic [2:0] code, output logic [108:0] dout);
    walk(8'h03, 4);
    shift({106'h0, code}, 3, dout);
  endtask
endmodule

// file: dv/memory_boundary_scan_tap_tb.sv
`timescale 1ns/1ns
module memory_boundary_scan_tap_tb;
  logic i_clk, i_resetn, tck, tms, tdi, tdo, tdo_oe_n, q_oe_n, extest;
  logic [108:0] pins, upd, d;
  int miscompares, total_checks;
  localparam logic [108:0] P1 = {1'h1, 108'h3a5_96f0_e1d2_b487_1e2d_3c4b_5a69};
  localparam logic [108:0] P2 = {1'h0, 108'h5a5_a5a5_0f0f_f0f0_1234_5678_9abc};
  mbst_tap mbst_tap_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_pins(pins), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .o_q_oe_n(q_oe_n),
    .o_extest(extest), .o_bsr_update(upd));
  mbst_ctrl_model mbst_ctrl_model_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
  initial begin
    i_clk = 1'h0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic check(input string n, input logic [108:0] s, input logic [108:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic set_pins(input logic [108:0] v);
    @(posedge i_clk);
    #1 pins = v;
  endtask
  task automatic t_idcode(input string t);
    mbst_ctrl_model_i.scan_dr(109'h1, 33, d);
    check("id length", d[32], 1'h1);
    check("tdo released", tdo_oe_n, 1'h1);
    check("version", d[31:29], mbst_pkg::ID_VERSION);
    check("part", d[28:12], mbst_pkg::ID_PART);
    check("maker", d[11:1], mbst_pkg::ID_MFR);
    check("present", d[0], 1'h1);
    check("q_oe_n", q_oe_n, 1'h0);
    $display("test %s done", t);
  endtask
  task automatic t_bypass;
    mbst_ctrl_model_i.scan_ir(mbst_pkg::INS_BYPASS, d);
    check("ir capture", d[1:0], 2'h1);
    mbst_ctrl_model_i.scan_dr(109'hb, 5, d);
    check("bypass out", d[4:0], 5'h16);
    check("q_oe_n", q_oe_n, 1'h0);
    $display("test bypass done");
  endtask
  task automatic t_sample;
    set_pins(P1);
    mbst_ctrl_model_i.scan_ir(mbst_pkg::INS_SAMPLE, d);
    mbst_ctrl_model_i.scan_dr(P2, 109, d);
    check("sampled", d, P1);
    check("preload", upd, P2);
    check("q_oe_n", q_oe_n, 1'h0);
    $display("test sample done");
  endtask
  task automatic t_extest;
    mbst_ctrl_model_i.scan_ir(mbst_pkg::INS_EXTEST, d);
    check("extest", extest, 1'h1);
    check("q_oe_n off", q_oe_n, 1'h1);
    set_pins(~P1);
    mbst_ctrl_model_i.scan_dr(P1, 109, d);
    check("captured", d, ~P1);
    check("q_oe_n on", q_oe_n, 1'h0);
    $display("test extest done");
  endtask
  task automatic t_hiz;
    mbst_ctrl_model_i.scan_ir(mbst_pkg::INS_HIZ_SAMPLE, d);
    check("q_oe_n hiz", q_oe_n, 1'h1);
    set_pins(P2);
    mbst_ctrl_model_i.scan_dr('0, 109, d);
    check("hiz sampled", d, P2);
    mbst_ctrl_model_i.walk(8'h1f, 6);
    check("cell 108", upd[108], 1'h1);
    check("q_oe_n", q_oe_n, 1'h0);
    $display("test hiz done");
  endtask
  initial begin
    i_resetn = 1'h0;
    pins = '0;
    miscompares = 0;
    total_checks = 0;
    repeat (3) @(posedge i_clk);
    #1 i_resetn = 1'h1;
    repeat (4) @(posedge i_clk);
    #1;
    check("reset bsr", upd, {1'h1, 108'h0});
    check("reset oe", tdo_oe_n, 1'h1);
    mbst_ctrl_model_i.walk(8'h1f, 6);
    t_idcode("idcode");
    t_bypass();
    t_sample();
    t_extest();
    t_hiz();
    t_idcode("logic reset");
    summarize();
  end
endmodule
